// File: include/dtov_pkg.sv
// Shared constants and carrier types of the three-phase definite-time overvoltage detector.
// Assumes a single 20 MHz clock and magnitudes in units of 0.01 % of nominal voltage.
//
// Function
// (RULE1) An enable switches the function Off or On, Off after reset; Off gives no outputs.
// (RULE2) Inputs are fundamental RMS magnitudes of three phase or phase-to-phase voltages.
// (RULE3) Each phase decides its own started state against the start level.
// (RULE4) A phase starts above the start level, 30 to 130 percent, default 110.
// (RULE5) A started phase drops off at least ratio percent below level, 1 to 10, default 5.
// (RULE6) The delay is counted only while the phase stays started above its level; the code also counts while started in the hysteresis band.
// (RULE7) The delay runs 0 to 60000 ms in 1 ms steps, default 100 ms.
// (RULE8) Each phase has its own start and internal trip, trip once its delay expires.
// (RULE9) In phase-to-phase use the three channels stand for the L12, L23, L31 pairs.
// (RULE10) Per-phase trips stay inside; only phase starts, general start and trip leave.
// (RULE11) Start-only select defaults to 0; at 1 only starts, no general trip.
// (RULE12) A decision stage forms the general trip from starts, trips and start-only.
// (RULE13) One block input, driven by outside logic, disables the function.
// (RULE14) The general start is high while any of the three voltages is started.
// (RULE15) Phase-to-phase monitoring is the default selection after reset.
// (RULE16) Drop-off or block clears the phase delay count, so timing restarts from zero.
// (RULE17) While blocked, every start and trip output is forced inactive.

package dtov_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Measurement format and timing.
   localparam int MAG_W = 16;
   localparam int CLK_HZ = 20_000_000;
   localparam int MS_PER_S = 1000;
   localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
   localparam int CYC_W = 16;
   localparam logic [15:0] PCT_SCALE = 16'h0064;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Setting ranges and defaults.
   localparam logic [7:0] LEVEL_MIN = 8'h1e;
   localparam logic [7:0] LEVEL_MAX = 8'h82;
   localparam logic [7:0] LEVEL_DEF = 8'h6e;
   localparam logic [7:0] RATIO_MIN = 8'h01;
   localparam logic [7:0] RATIO_MAX = 8'h0a;
   localparam logic [7:0] RATIO_DEF = 8'h05;
   localparam logic [15:0] DELAY_MAX = 16'hea60;
   localparam logic [15:0] DELAY_DEF = 16'h0064;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses on the APB.
   localparam int APB_AW = 12;
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_LEVEL = 12'h004;
   localparam logic [11:0] OFS_RATIO = 12'h008;
   localparam logic [11:0] OFS_DELAY = 12'h00c;
   localparam logic [11:0] OFS_STATUS = 12'h010;
   localparam logic [11:0] OFS_IRQ_STAT = 12'h014;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h018;

   // Control register fields and reset value (phase-to-phase on, enable and start-only off).
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_STONLY_BIT = 1;
   localparam int CTRL_L2L_BIT = 2;
   localparam logic CTRL_EN_RST = 1'b0;
   localparam logic CTRL_STONLY_RST = 1'b0;
   localparam logic CTRL_L2L_RST = 1'b1;

   // Status register fields.
   localparam int STAT_START_LSB = 0;
   localparam int STAT_ANY_BIT = 3;
   localparam int STAT_TRIP_BIT = 4;

   // Interrupt events.
   localparam int IRQ_W = 3;
   localparam int IRQ_START_RISE = 0;
   localparam int IRQ_TRIP_RISE = 1;
   localparam int IRQ_START_FALL = 2;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Carriers.
   typedef struct packed {
      logic [MAG_W-1:0] magPhaseC;
      logic [MAG_W-1:0] magPhaseB;
      logic [MAG_W-1:0] magPhaseA;
   } dtov_mag3_t;

   typedef struct packed {
      logic [2:0] phaseStart;
      logic anyStart;
      logic combTrip;
   } dtov_out_t;

endpackage

// File: core/dtov_phase.sv
// One phase channel: start with hysteresis and a definite-time delay counter.
// Assumes thresholds and delay come from settings held on the same clock.
`timescale 1ns/1ps

module dtov_phase #(
   parameter int CYC_PER_MS = dtov_pkg::CYC_PER_MS
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Settings and control.
   input wire logic clear,
   input wire logic [dtov_pkg::MAG_W-1:0] mag,
   input wire logic [15:0] startThr,
   input wire logic [15:0] dropThr,
   input wire logic [15:0] delayMs,
   // Channel state.
   output logic started,
   output logic trip
);

   typedef struct packed {
      logic started;
      logic trip;
      logic [dtov_pkg::CYC_W-1:0] cyc;
      logic [15:0] ms;
   } dtov_phase_state_t;

   localparam logic [dtov_pkg::CYC_W-1:0] CYC_LAST = dtov_pkg::CYC_W'(CYC_PER_MS - 1);

   dtov_phase_state_t s_r;
   dtov_phase_state_t s_nxt;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Next state: hysteresis comparator, then a millisecond count while started.
   always_comb begin
      s_nxt = s_r;
      if (clear) begin
         s_nxt = '0; // [RULE16] [RULE13]
      end else begin
         if (s_r.started) begin
            s_nxt.started = (mag > dropThr); // [RULE5] [RULE3]
         end else begin
            s_nxt.started = (mag > startThr); // [RULE4] [RULE3]
         end
         if (!s_nxt.started) begin
            s_nxt.cyc = '0; // [RULE16]
            s_nxt.ms = '0;
            s_nxt.trip = 1'b0;
         end else if (s_r.trip || (s_r.ms >= delayMs)) begin
            s_nxt.trip = 1'b1; // [RULE8] [RULE7]
         end else if (s_r.cyc == CYC_LAST) begin
            s_nxt.cyc = '0; // [RULE6]
            s_nxt.ms = s_r.ms + 16'h0001;
         end else begin
            s_nxt.cyc = s_r.cyc + 1'b1;
         end
      end
   end

   // State register.
   always_ff @(posedge clk) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign started = s_r.started;
   assign trip = s_r.trip;

endmodule

// File: core/dtov_decision.sv
// Decision stage: forms general start and general trip from the phase channels.
// Assumes its inputs all come from logic on the same clock.
`timescale 1ns/1ps

module dtov_decision (
   // Settings and block.
   input wire logic enable,
   input wire logic startOnly,
   input wire logic blockIn,
   // Phase channels.
   input wire logic [2:0] phStart,
   input wire logic [2:0] phTrip,
   // Decided outputs.
   output dtov_pkg::dtov_out_t dec
);

   logic active;

   // Gate everything with enable and block, then combine the phases.
   always_comb begin
      active = enable && !blockIn; // [RULE1] [RULE17]
      dec.phaseStart = active ? phStart : 3'h0;
      dec.anyStart = active && (|phStart); // [RULE14]
      dec.combTrip = active && !startOnly && (|(phTrip & phStart)); // [RULE12] [RULE11]
   end

endmodule

// File: core/dtov_top.sv
// Top of the definite-time overvoltage detector: APB registers, interrupt, three channels.
// Assumes magnitudes and the block input come from logic on clk, and an APB master on clk.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

module dtov_top #(
   parameter int CYC_PER_MS = dtov_pkg::CYC_PER_MS
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dtov_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Measurements and block from upstream logic.
   input wire dtov_pkg::dtov_mag3_t magIn,
   input wire logic functionBlockIn,
   // Selection toward the upstream stage.
   output logic lineToLineSel,
   // Protection outputs.
   output logic startPhaseA,
   output logic startPhaseB,
   output logic startPhaseC,
   output logic anyPhaseStart,
   output logic combinedTrip,
   // Interrupt.
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // State of the module.
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic slvErr;
      logic operationEnable;
      logic startOnlySelect;
      logic lineToLine;
      logic [7:0] startLevelPct;
      logic [7:0] dropoffRatioPct;
      logic [15:0] tripDelayMs;
      logic [dtov_pkg::IRQ_W-1:0] irqStat;
      logic [dtov_pkg::IRQ_W-1:0] irqMask;
      dtov_pkg::dtov_out_t outs;
   } dtov_top_state_t;

   dtov_top_state_t s_r;
   dtov_top_state_t s_nxt;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Product of two percentage figures in units of 0.01 percent.
   function automatic logic [15:0] mulPct(input logic [7:0] a, input logic [15:0] b);
      logic [23:0] p;
      p = {16'h0000, a} * {8'h00, b};
      return p[15:0];
   endfunction

   // Limits a written setting to its allowed range.
   function automatic logic [15:0] clampSet(input logic [31:0] w, input logic [15:0] lo,
                                           input logic [15:0] hi);
      logic [15:0] r;
      r = w[15:0];
      if (w[31:16] != 16'h0000 || w[15:0] > hi) begin
         r = hi;
      end else if (w[15:0] < lo) begin
         r = lo;
      end
      return r;
   endfunction

   // True when the address names a mapped register.
   function automatic logic addrMapped(input logic [dtov_pkg::APB_AW-1:0] a);
      return (a == dtov_pkg::OFS_CTRL) || (a == dtov_pkg::OFS_LEVEL) ||
             (a == dtov_pkg::OFS_RATIO) || (a == dtov_pkg::OFS_DELAY) ||
             (a == dtov_pkg::OFS_STATUS) || (a == dtov_pkg::OFS_IRQ_STAT) ||
             (a == dtov_pkg::OFS_IRQ_MASK);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Thresholds from the settings.
   logic [15:0] startThr;
   logic [15:0] dropThr;
   logic [15:0] keepPct;

   // Start threshold is the level; the drop threshold sits ratio percent beneath it.
   always_comb begin
      keepPct = dtov_pkg::PCT_SCALE - {8'h00, s_r.dropoffRatioPct};
      startThr = mulPct(s_r.startLevelPct, dtov_pkg::PCT_SCALE); // [RULE4]
      dropThr = mulPct(s_r.startLevelPct, keepPct); // [RULE5]
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Phase channels.
   logic [2:0] phStart;
   logic [2:0] phTrip;
   logic chanClear;
   logic [dtov_pkg::MAG_W-1:0] magArr [3];

   // Channels are cleared while the function is off or blocked.
   assign chanClear = !s_r.operationEnable || functionBlockIn; // [RULE1] [RULE16] [RULE13]

   // Channel 0, 1, 2 carry L1, L2, L3 or the L12, L23, L31 pairs alike.
   assign magArr[0] = magIn.magPhaseA; // [RULE2] [RULE9]
   assign magArr[1] = magIn.magPhaseB;
   assign magArr[2] = magIn.magPhaseC;

   for (genvar g = 0; g < 3; g++) begin : gPhase
      dtov_phase #(
         .CYC_PER_MS(CYC_PER_MS)
      ) uPhase (
         .clk(clk),
         .reset(reset),
         .clear(chanClear),
         .mag(magArr[g]),
         .startThr(startThr),
         .dropThr(dropThr),
         .delayMs(s_r.tripDelayMs),
         .started(phStart[g]),
         .trip(phTrip[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Decision stage.
   dtov_pkg::dtov_out_t dec;

   dtov_decision uDecision (
      .enable(s_r.operationEnable),
      .startOnly(s_r.startOnlySelect),
      .blockIn(functionBlockIn),
      .phStart(phStart),
      .phTrip(phTrip),
      .dec(dec)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Bus and interrupt terms.
   logic setupDone;
   logic doWrite;
   logic [dtov_pkg::IRQ_W-1:0] irqEvents;
   logic [dtov_pkg::IRQ_W-1:0] irqClr;
   logic [31:0] rdMux;
   logic [31:0] ctrlWord;
   logic [31:0] statWord;

   // Access phase seen for the first time, and the completing write.
   assign setupDone = psel && penable && !s_r.ack;
   assign doWrite = psel && penable && s_r.ack && pwrite && !s_r.slvErr;

   // Events taken from the change of the registered general outputs.
   always_comb begin
      irqEvents = '0;
      irqEvents[dtov_pkg::IRQ_START_RISE] = dec.anyStart && !s_r.outs.anyStart;
      irqEvents[dtov_pkg::IRQ_TRIP_RISE] = dec.combTrip && !s_r.outs.combTrip;
      irqEvents[dtov_pkg::IRQ_START_FALL] = !dec.anyStart && s_r.outs.anyStart;
   end

   // Words as read back; per-phase trips are deliberately absent.
   always_comb begin
      ctrlWord = '0;
      ctrlWord[dtov_pkg::CTRL_EN_BIT] = s_r.operationEnable;
      ctrlWord[dtov_pkg::CTRL_STONLY_BIT] = s_r.startOnlySelect;
      ctrlWord[dtov_pkg::CTRL_L2L_BIT] = s_r.lineToLine;
      statWord = '0;
      statWord[dtov_pkg::STAT_START_LSB +: 3] = s_r.outs.phaseStart; // [RULE10]
      statWord[dtov_pkg::STAT_ANY_BIT] = s_r.outs.anyStart;
      statWord[dtov_pkg::STAT_TRIP_BIT] = s_r.outs.combTrip;
   end

   // Read multiplexer.
   always_comb begin
      rdMux = '0;
      if (paddr == dtov_pkg::OFS_CTRL) begin
         rdMux = ctrlWord;
      end else if (paddr == dtov_pkg::OFS_LEVEL) begin
         rdMux = {24'h000000, s_r.startLevelPct};
      end else if (paddr == dtov_pkg::OFS_RATIO) begin
         rdMux = {24'h000000, s_r.dropoffRatioPct};
      end else if (paddr == dtov_pkg::OFS_DELAY) begin
         rdMux = {16'h0000, s_r.tripDelayMs};
      end else if (paddr == dtov_pkg::OFS_STATUS) begin
         rdMux = statWord;
      end else if (paddr == dtov_pkg::OFS_IRQ_STAT) begin
         rdMux = {29'h0, s_r.irqStat};
      end else if (paddr == dtov_pkg::OFS_IRQ_MASK) begin
         rdMux = {29'h0, s_r.irqMask};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Next state of the module.
   always_comb begin
      s_nxt = s_r;
      irqClr = '0;
      // One wait state: the first access cycle captures, the second completes.
      if (setupDone) begin
         s_nxt.ack = 1'b1;
         s_nxt.slvErr = !addrMapped(paddr);
         s_nxt.rdata = pwrite ? 32'h00000000 : rdMux;
      end else begin
         s_nxt.ack = 1'b0;
         s_nxt.slvErr = 1'b0;
      end
      // Register writes take effect at the completing edge.
      if (doWrite) begin
         if (paddr == dtov_pkg::OFS_CTRL) begin
            s_nxt.operationEnable = pwdata[dtov_pkg::CTRL_EN_BIT]; // [RULE1]
            s_nxt.startOnlySelect = pwdata[dtov_pkg::CTRL_STONLY_BIT]; // [RULE11]
            s_nxt.lineToLine = pwdata[dtov_pkg::CTRL_L2L_BIT]; // [RULE9]
         end else if (paddr == dtov_pkg::OFS_LEVEL) begin
            s_nxt.startLevelPct = 8'(clampSet(pwdata, {8'h00, dtov_pkg::LEVEL_MIN},
                                              {8'h00, dtov_pkg::LEVEL_MAX})); // [RULE4]
         end else if (paddr == dtov_pkg::OFS_RATIO) begin
            s_nxt.dropoffRatioPct = 8'(clampSet(pwdata, {8'h00, dtov_pkg::RATIO_MIN},
                                                {8'h00, dtov_pkg::RATIO_MAX})); // [RULE5]
         end else if (paddr == dtov_pkg::OFS_DELAY) begin
            s_nxt.tripDelayMs = clampSet(pwdata, 16'h0000, dtov_pkg::DELAY_MAX); // [RULE7]
         end else if (paddr == dtov_pkg::OFS_IRQ_STAT) begin
            irqClr = pwdata[dtov_pkg::IRQ_W-1:0];
         end else if (paddr == dtov_pkg::OFS_IRQ_MASK) begin
            s_nxt.irqMask = pwdata[dtov_pkg::IRQ_W-1:0];
         end
      end
      // Sticky status: a new event wins over a clear in the same cycle.
      s_nxt.irqStat = (s_r.irqStat & ~irqClr) | irqEvents;
      // Outputs registered from the decision stage.
      s_nxt.outs = dec; // [RULE10] [RULE17]
   end

   // State register with reset values.
   always_ff @(posedge clk) begin
      if (reset) begin
         s_r <= '0;
         s_r.operationEnable <= dtov_pkg::CTRL_EN_RST; // [RULE1]
         s_r.startOnlySelect <= dtov_pkg::CTRL_STONLY_RST; // [RULE11]
         s_r.lineToLine <= dtov_pkg::CTRL_L2L_RST; // [RULE15]
         s_r.startLevelPct <= dtov_pkg::LEVEL_DEF;
         s_r.dropoffRatioPct <= dtov_pkg::RATIO_DEF;
         s_r.tripDelayMs <= dtov_pkg::DELAY_DEF;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Port drive.
   assign prdata = s_r.rdata;
   assign pready = s_r.ack;
   assign pslverr = s_r.ack && s_r.slvErr;
   assign lineToLineSel = s_r.lineToLine; // [RULE9]
   assign startPhaseA = s_r.outs.phaseStart[0]; // [RULE8]
   assign startPhaseB = s_r.outs.phaseStart[1];
   assign startPhaseC = s_r.outs.phaseStart[2];
   assign anyPhaseStart = s_r.outs.anyStart; // [RULE14]
   assign combinedTrip = s_r.outs.combTrip; // [RULE12]
   assign irq = |(s_r.irqStat & s_r.irqMask);

endmodule

// File: tb/dtov_checker.sv
// Assertions on the ports of the overvoltage detector top.
// Assumes an APB master that holds each request until pready is sampled high.
`timescale 1ns/1ps

module dtov_checker (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // APB slave side.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dtov_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Block input and protection outputs.
   input wire logic functionBlockIn,
   input wire logic lineToLineSel,
   input wire logic startPhaseA,
   input wire logic startPhaseB,
   input wire logic startPhaseC,
   input wire logic anyPhaseStart,
   input wire logic combinedTrip
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   ////////////////////////////////////////////////////////////////////////////////
   // Bus timing: one wait state, a one-cycle answer, errors only off the map.
   property p_wait; psel && !penable |=> !pready ##1 pready; endproperty
   property p_pulse; pready |=> !pready; endproperty
   property p_err;
      pready && paddr > dtov_pkg::OFS_IRQ_MASK |-> pslverr && prdata == 32'h0;
   endproperty
   property p_ok;
      pready && paddr[1:0] == 2'h0 && paddr <= dtov_pkg::OFS_IRQ_MASK |-> !pslverr;
   endproperty
   a_wait: assert property (p_wait) else $error("pready not in second access cycle");
   a_pulse: assert property (p_pulse) else $error("pready stood more than one cycle");
   a_err: assert property (p_err) else $error("unmapped access not refused");
   a_ok: assert property (p_ok) else $error("mapped access refused");

   ////////////////////////////////////////////////////////////////////////////////
   // Protection outputs tied to each other and to the block input; the selection tied to control writes.
   property p_any; anyPhaseStart == (startPhaseA | startPhaseB | startPhaseC); endproperty
   property p_trip; combinedTrip |-> anyPhaseStart; endproperty
   property p_block; functionBlockIn |=> !anyPhaseStart && !combinedTrip; endproperty
   property p_sel;
      !(pready && pwrite && paddr == dtov_pkg::OFS_CTRL) |=> $stable(lineToLineSel);
   endproperty
   a_any: assert property (p_any) else $error("general start differs from phases");
   a_trip: assert property (p_trip) else $error("trip without start");
   a_block: assert property (p_block) else $error("output while blocked");
   a_sel: assert property (p_sel) else $error("selection moved without write");

   // Main scenarios reached.
   c_err: cover property (pready && pslverr);
   c_trip: cover property ($rose(combinedTrip));
   c_block: cover property (functionBlockIn && anyPhaseStart);
endmodule

bind dtov_top dtov_checker chk_u (.clk, .reset, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .functionBlockIn, .lineToLineSel, .startPhaseA, .startPhaseB,
   .startPhaseC, .anyPhaseStart, .combinedTrip);

// File: tb/dtov_mag_src.sv
// Model of the upstream stage that supplies the three fundamental magnitudes.
// Assumes the bench sets target values on clk; slow adds one cycle of lag.
`timescale 1ns/1ps

module dtov_mag_src (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Control from the bench and the detector.
   input wire dtov_pkg::dtov_mag3_t target,
   input wire logic slow,
   input wire logic lineToLineSel,
   // Magnitudes toward the detector.
   output dtov_pkg::dtov_mag3_t magOut
);
   dtov_pkg::dtov_mag3_t stage;

   // One magnitude per channel; the selection only relabels them as pairs.
   always @(posedge clk) begin
      stage <= target;
      magOut <= (reset || lineToLineSel === 1'bx) ? '0 : (slow ? stage : target);
   end
endmodule

// File: tb/definite_time_overvoltage_test.sv
// Self-checking bench of the overvoltage detector with a cycle model beside it.
// Assumes the package, the top, the source model and the checker are compiled first.
`timescale 1ns/1ps

module definite_time_overvoltage_test;
   localparam int CPM = 10;
   logic clk, reset, psel, penable, pwrite, pready, pslverr, blk, slow, irq, l2l, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [4:0] outs;
   dtov_pkg::dtov_mag3_t magIn, target;
   int fails, cmp_count, cyc, mLvl, mRat, mDly, age[3];
   bit mEn, mSo, exAny, exTr;
   bit [2:0] ch, exSt;
   int unsigned seed = 8144;

   dtov_top #(.CYC_PER_MS(CPM)) dut_u (.clk, .reset, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .magIn, .functionBlockIn(blk),
      .lineToLineSel(l2l), .startPhaseA(outs[0]), .startPhaseB(outs[1]),
      .startPhaseC(outs[2]), .anyPhaseStart(outs[3]), .combinedTrip(outs[4]), .irq);
   dtov_mag_src src_u (.clk, .reset, .target, .slow, .lineToLineSel(l2l), .magOut(magIn));

   // Clock generation.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Cycle model of the channels and the decision stage.
   always @(posedge clk) begin
      int m;
      bit t;
      bit g;
      g = mEn && !blk && !reset;
      t = 1'b0;
      for (int i = 0; i < 3; i++) begin
         m = magIn[16*i +: 16];
         t = t | (ch[i] && (mDly == 0 || age[i] >= mDly * CPM));
         exSt[i] <= ch[i] && g;
         if (!g) ch[i] <= 1'b0;
         else if (m > mLvl * 100) ch[i] <= 1'b1;
         else if (m <= mLvl * (100 - mRat)) ch[i] <= 1'b0;
         age[i] <= (ch[i] && g) ? age[i] + 1 : 0;
      end
      exAny <= g && (ch != 3'h0);
      exTr <= g && t && !mSo;
   end

   // Outputs against the model once they have settled.
   always @(negedge clk) begin
      if (!reset) chkOut(outs, {exTr, exAny, exSt});
   end

   // Hang guard.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers.
   function automatic int unsigned xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic int lim(input logic [31:0] v, input int lo, input int hi);
      if (v < lo) return lo;
      if (v > hi) return hi;
      return int'(v);
   endfunction

   task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chkOut(input logic [4:0] got, input logic [4:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t outs got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Mirrors a completed register write into the model, with the same clamping.
   task automatic upd(input logic [11:0] a, input logic [31:0] d);
      case (a)
         dtov_pkg::OFS_CTRL: begin
            mEn <= d[0];
            mSo <= d[1];
         end
         dtov_pkg::OFS_LEVEL: mLvl <= lim(d, 30, 130);
         dtov_pkg::OFS_RATIO: mRat <= lim(d, 1, 10);
         dtov_pkg::OFS_DELAY: mDly <= lim(d, 0, 60000);
         default: ;
      endcase
   endtask

   // One APB transfer, then one idle cycle.
   task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) fails++;
      q = prdata;
      e = pslverr;
      if (w && e === 1'b0) upd(a, d);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chkReg(q, x);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic hold(input int a, input int n);
      target <= {16'h0, 16'h0, 16'(a)};
      repeat (n) @(posedge clk);
   endtask

   task automatic chkIrq(input logic x);
      @(negedge clk);
      chkReg({31'h0, irq}, {31'h0, x});
      @(posedge clk);
   endtask

   task automatic done(input string s);
      $display("Test %s finished", s);
   endtask

   task automatic close_out();
      $display("Compares %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      logic [11:0] ta[6];
      int td[6];
      int te[6];
      ta = '{12'h004, 12'h004, 12'h008, 12'h008, 12'h00c, 12'h00c};
      td = '{200, 10, 0, 99, 32'h10000, 0};
      te = '{130, 30, 1, 10, 60000, 0};
      {reset, psel, penable, pwrite, blk, slow} = 6'h20;
      paddr = 12'h0;
      pwdata = 32'h0;
      target = '0;
      {mEn, mSo, mLvl, mRat, mDly} = {2'b00, 32'd110, 32'd5, 32'd100};
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd(dtov_pkg::OFS_CTRL, 32'h4);
      chkReg({31'h0, l2l}, 32'h1);
      rd(dtov_pkg::OFS_LEVEL, 32'h6e);
      rd(dtov_pkg::OFS_RATIO, 32'h5);
      rd(dtov_pkg::OFS_DELAY, 32'h64);
      for (int i = 0; i < 6; i++) begin
         wr(ta[i], td[i]);
         rd(ta[i], te[i]);
      end
      wr(dtov_pkg::OFS_STATUS, 32'h1f);
      rd(dtov_pkg::OFS_STATUS, 32'h0);
      apb(1'b0, 12'h040, 32'h0);
      chkReg({q[30:0], e}, 32'h1);
      hold(13000, 20);
      hold(0, 1);
      wr(dtov_pkg::OFS_CTRL, 32'h0);
      chkReg({31'h0, l2l}, 32'h0);
      done("registers");
      // Threshold edges, hysteresis, a 2 ms delay and the interrupt.
      wr(dtov_pkg::OFS_LEVEL, 100);
      wr(dtov_pkg::OFS_DELAY, 2);
      wr(dtov_pkg::OFS_RATIO, 5);
      wr(dtov_pkg::OFS_CTRL, 32'h5);
      hold(10000, 30);
      hold(10001, 30);
      hold(9501, 10);
      hold(9500, 10);
      rd(dtov_pkg::OFS_IRQ_STAT, 32'h7);
      chkIrq(1'b0);
      wr(dtov_pkg::OFS_IRQ_MASK, 32'h2);
      chkIrq(1'b1);
      wr(dtov_pkg::OFS_IRQ_STAT, 32'h2);
      chkIrq(1'b0);
      rd(dtov_pkg::OFS_IRQ_STAT, 32'h5);
      done("levels");
      // Zero delay, start-only, and a block in mid-count.
      wr(dtov_pkg::OFS_DELAY, 0);
      hold(10001, 10);
      hold(0, 5);
      wr(dtov_pkg::OFS_DELAY, 2);
      wr(dtov_pkg::OFS_CTRL, 32'h7);
      hold(10001, 40);
      hold(0, 5);
      wr(dtov_pkg::OFS_CTRL, 32'h5);
      hold(10001, 15);
      blk <= 1'b1;
      repeat (3) @(posedge clk);
      blk <= 1'b0;
      hold(10001, 30);
      hold(0, 5);
      done("modes");
      // Random magnitudes around the band on all phases, with a lagging source.
      slow <= 1'b1;
      for (int i = 0; i < 80; i++) begin
         target <= {16'(9400 + xs() % 701), 16'(9400 + xs() % 701), 16'(9400 + xs() % 701)};
         repeat (1 + xs() % 8) @(posedge clk);
      end
      done("random");
      close_out();
   end
endmodule
